// file: hdl/vic_pkg.sv
// Notes on behaviour
// (R1) There are 38 vectored sources: 9 maskable events, exceptions with reset, 16 traps, 7 software.
// (R2) Each event takes one of 8 priority levels and needs both the global and its own enable.
// (R3) One global enable bit sits in the low event-enable register, per-source bits in low or high.
// (R4) Priority fields hold three bits; the effective value is that with a fourth top bit of one, except zero.
// (R5) Equal-priority requests are served in fixed arbitration rank order, rank 0 first.
// (R6) Hardware, watchdog and software resets use vector 0000 and outrank every other source.
// (R7) Hardware traps rank 1 with vectors 0004, 0008, 000C, 0010 and 0014, four bytes each.
// (R8) The sixteen software traps vector into 0040-007F, four bytes each, with rank 1.
// (R9) Event vectors are 0080, 0084, 0088, 008C, 0090, 00A0, 00A4, 00A8 and 00AC.
// (R10) Priority fields sit in bits 2-0 or 6-4 of priority registers 0, 1, 2, 4 and 5.
// (R11) Event ranks run 2 to 10: ext 0, timer 0, ext 1, timer 1, timer 2, uart0 rx/tx, uart1 rx/tx.
// (R12) Software interrupts come only from software requests, traps only from trap instructions.
// (R13) After reset release a reset exception fetches vector 0000; all vectors are 16-bit page-zero values (software interrupts here use 0100-0118).
// (R14) In idle, a pending enabled interrupt wakes the processor.
// (R15) Power-down is left by reset or by an enabled, level-sensitive external interrupt.
// (R16) The pending enabled request of highest effective priority is presented, rank breaking ties.
package vic_pkg;
  localparam int NUM_EVT = 9;
  localparam int NUM_SWI = 7;
  localparam int NUM_HWTRAP = 5;
  localparam int NUM_SWTRAP = 16;
  localparam int NUM_ARB = NUM_EVT + NUM_SWI; // (R1)
  localparam int NUM_PRI_REG = 6;
  // Register byte offsets
  localparam logic [7:0] ADDR_EN_LO = 8'h00;
  localparam logic [7:0] ADDR_EN_HI = 8'h04;
  localparam logic [7:0] ADDR_PRI_BASE = 8'h08;
  localparam logic [7:0] ADDR_PRI_LAST = 8'h1C;
  localparam logic [7:0] ADDR_PRI_HOLE = 8'h14;
  localparam logic [7:0] ADDR_SWREQ = 8'h20;
  localparam logic [7:0] ADDR_SWEN = 8'h24;
  localparam logic [7:0] ADDR_EXTLVL = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_MASK = 8'h30;
  localparam logic [7:0] ADDR_VECTOR = 8'h34;
  // Field positions
  localparam int EN_GLOBAL_BIT = 7;
  localparam int PRI_LO_POS = 0;
  localparam int PRI_HI_POS = 4;
  localparam int ST_VEC_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_RESET_BIT = 2;
  localparam int VECREG_VALID_BIT = 16;
  // Reset values
  localparam logic [7:0] EN_LO_RST = 8'h00;
  localparam logic [3:0] EN_HI_RST = 4'h0;
  localparam logic [7:0] PRI_RST = 8'h00;
  localparam logic [6:0] SWI_RST = 7'h00;
  localparam logic [1:0] EXTLVL_RST = 2'h0;
  localparam logic [2:0] STAT_RST = 3'h0;
  // Vectors
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_HWTRAP_BASE = 16'h0004;
  localparam logic [15:0] VEC_SWTRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_SWI_BASE = 16'h0100;

  typedef enum logic {ST_IDLE, ST_PRESENT} vic_state_e;
  typedef enum logic [1:0] {K_RESET, K_HWTRAP, K_SWTRAP, K_ARB} vic_kind_e;

  function automatic logic [3:0] vic_eff_pri(input logic [2:0] p);
    vic_eff_pri = (p == 3'h0) ? 4'h0 : {1'b1, p}; // (R4)
  endfunction

  function automatic logic [15:0] vic_evt_vec(input int i);
    case (i) // (R9)
      0: vic_evt_vec = 16'h0080;
      1: vic_evt_vec = 16'h0084;
      2: vic_evt_vec = 16'h0088;
      3: vic_evt_vec = 16'h008C;
      4: vic_evt_vec = 16'h0090;
      5: vic_evt_vec = 16'h00A0;
      6: vic_evt_vec = 16'h00A4;
      7: vic_evt_vec = 16'h00A8;
      default: vic_evt_vec = 16'h00AC;
    endcase
  endfunction

  // Register holding each event's field, and whether it is the high nibble
  function automatic int vic_pri_reg(input int i);
    case (i) // (R10)
      0, 1: vic_pri_reg = 0;
      2, 3: vic_pri_reg = 1;
      4: vic_pri_reg = 2;
      5, 6: vic_pri_reg = 4;
      default: vic_pri_reg = 5;
    endcase
  endfunction

  function automatic logic vic_pri_hi(input int i);
    vic_pri_hi = (i == 1) || (i == 3) || (i == 6) || (i == 8); // (R10)
  endfunction
endpackage

// file: hdl/vic_arb.sv
`timescale 1ns/10ps
`default_nettype none
module vic_arb #(
  parameter int N = 16
) (
  input wire logic [N-1:0] req,
  input wire logic [4*N-1:0] pri,
  output logic found,
  output logic [$clog2(N)-1:0] idx,
  output logic [3:0] best
);
  import vic_pkg::*;

  // A single lane leaves nothing to arbitrate and a zero-width index
  if (N < 2) begin : g_too_few
    $error("vic_arb needs at least two lanes");
  end

  // Lane order is rank order; strict greater-than keeps the lower lane on a tie
  always_comb begin
    found = 1'b0;
    idx = '0;
    best = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || pri[4*i +: 4] > best)) begin // (R16) (R5)
        found = 1'b1;
        idx = i[$clog2(N)-1:0];
        best = pri[4*i +: 4];
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/vic_top.sv
`timescale 1ns/10ps
`default_nettype none
module vic_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic ext_irq0_flag,
  input wire logic ext_irq1_flag,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  input wire logic uart0_rx_flag,
  input wire logic uart0_tx_flag,
  input wire logic uart1_rx_flag,
  input wire logic uart1_tx_flag,
  input wire logic [3:0] core_pri,
  input wire logic [vic_pkg::NUM_HWTRAP-1:0] hw_trap,
  input wire logic swtrap_req,
  input wire logic [3:0] swtrap_num,
  input wire logic wdt_reset,
  input wire logic sw_reset,
  input wire logic vec_ack,
  output logic vec_valid_ff,
  output logic [15:0] vec_addr_ff,
  input wire logic idle_mode,
  input wire logic pd_mode,
  input wire logic [1:0] ext_irq_n_pin,
  output logic wake_ff,
  output logic irq_ff
);
  import vic_pkg::*;

  // Lane and trap selects are four bits wide
  if (NUM_ARB > 16 || NUM_SWTRAP > 16 || NUM_HWTRAP > 8) begin : g_bad_width
    $error("vic_top select width too narrow");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and pending state
  logic [7:0] en_lo_ff;
  logic [3:0] en_hi_ff;
  logic [7:0] pri_ff [NUM_PRI_REG];
  logic [6:0] swreq_ff;
  logic [6:0] swen_ff;
  logic [1:0] extlvl_ff;
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic rst_pend_ff;
  logic [NUM_HWTRAP-1:0] hwtrap_pend_ff;
  logic [NUM_SWTRAP-1:0] swtrap_pend_ff;
  vic_state_e state_ff;
  vic_kind_e kind_ff;
  logic [3:0] sel_ff;

  logic setup;
  logic acc_wr;
  logic hit;
  logic [31:0] rd_mux;
  logic [NUM_EVT-1:0] evt_flag;
  logic [NUM_EVT-1:0] evt_en;
  logic [NUM_ARB-1:0] arb_req;
  logic [4*NUM_ARB-1:0] arb_pri;
  logic arb_found;
  logic [3:0] arb_idx;
  logic [3:0] arb_best;
  logic cand_valid;
  vic_kind_e cand_kind;
  logic [3:0] cand_sel;
  logic [15:0] cand_vec;
  logic taken;
  logic nxt_wake;
  logic [2:0] st_set;
  logic [NUM_HWTRAP-1:0] hw_clr;
  logic [NUM_SWTRAP-1:0] sw_clr;
  logic [2:0] st_clr;
  logic taken_rst;
  logic taken_hw;
  logic taken_sw;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, pready rises the cycle after setup
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready_ff && pwrite && hit;

  // Priority register index from a byte offset; the hole is screened by hit
  function automatic logic [2:0] pri_index(input logic [7:0] a);
    pri_index = 3'((a - ADDR_PRI_BASE) >> 2);
  endfunction

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      ADDR_EN_LO: rd_mux[7:0] = en_lo_ff;
      ADDR_EN_HI: rd_mux[3:0] = en_hi_ff;
      ADDR_SWREQ: rd_mux[6:0] = swreq_ff;
      ADDR_SWEN: rd_mux[6:0] = swen_ff;
      ADDR_EXTLVL: rd_mux[1:0] = extlvl_ff;
      ADDR_STATUS: rd_mux[2:0] = status_ff;
      ADDR_MASK: rd_mux[2:0] = mask_ff;
      ADDR_VECTOR: rd_mux[VECREG_VALID_BIT:0] = {vec_valid_ff, vec_addr_ff};
      default: begin
        if (paddr >= ADDR_PRI_BASE && paddr <= ADDR_PRI_LAST && paddr[1:0] == 2'b00
            && paddr != ADDR_PRI_HOLE) begin
          rd_mux[7:0] = pri_ff[pri_index(paddr)] & 8'h77; // (R4)
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= rd_mux;
        pslverr_ff <= !hit;
      end
    end
  end

  // Only the three implemented bits of each field are stored
  always_ff @(posedge clk) begin
    if (rst) begin
      en_lo_ff <= EN_LO_RST;
      en_hi_ff <= EN_HI_RST;
      swreq_ff <= SWI_RST;
      swen_ff <= SWI_RST;
      extlvl_ff <= EXTLVL_RST;
      mask_ff <= STAT_RST;
      for (int r = 0; r < NUM_PRI_REG; r++) begin
        pri_ff[r] <= PRI_RST;
      end
    end else if (acc_wr) begin
      case (paddr)
        ADDR_EN_LO: en_lo_ff <= pwdata[7:0] & 8'h9F; // (R3)
        ADDR_EN_HI: en_hi_ff <= pwdata[3:0]; // (R3)
        ADDR_SWREQ: swreq_ff <= pwdata[6:0]; // (R12)
        ADDR_SWEN: swen_ff <= pwdata[6:0];
        ADDR_EXTLVL: extlvl_ff <= pwdata[1:0];
        ADDR_MASK: mask_ff <= pwdata[2:0];
        ADDR_STATUS: ;
        ADDR_VECTOR: ;
        default: pri_ff[pri_index(paddr)] <= pwdata[7:0] & 8'h77; // (R10)
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event and software request lanes
  assign evt_flag = {uart1_tx_flag, uart1_rx_flag, uart0_tx_flag, uart0_rx_flag,
                     timer2_overflow_flag | timer2_external_flag, timer1_overflow_flag,
                     ext_irq1_flag, timer0_overflow_flag, ext_irq0_flag};
  assign evt_en = {en_hi_ff, en_lo_ff[4], en_lo_ff[3], en_lo_ff[1], en_lo_ff[2], en_lo_ff[0]};

  always_comb begin
    arb_req = '0;
    arb_pri = '0;
    // Lanes 0..8 are events in rank order 2..10, then software 1..7
    for (int i = 0; i < NUM_EVT; i++) begin
      arb_req[i] = evt_flag[i] && evt_en[i] && en_lo_ff[EN_GLOBAL_BIT]; // (R2) (R3) (R11)
      arb_pri[4*i +: 4] = vic_pri_hi(i)
          ? vic_eff_pri(pri_ff[vic_pri_reg(i)][PRI_HI_POS +: 3])
          : vic_eff_pri(pri_ff[vic_pri_reg(i)][PRI_LO_POS +: 3]); // (R4) (R10)
    end
    for (int n = 0; n < NUM_SWI; n++) begin
      arb_req[NUM_EVT + n] = swreq_ff[n] && swen_ff[n]; // (R12)
      arb_pri[4*(NUM_EVT + n) +: 4] = 4'(n + 1);
    end
  end

  vic_arb #(
    .N(NUM_ARB)
  ) u_arb (
    .req(arb_req),
    .pri(arb_pri),
    .found(arb_found),
    .idx(arb_idx),
    .best(arb_best)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Source selection; exceptions and traps are not masked by core priority
  always_comb begin
    cand_valid = 1'b1;
    cand_kind = K_ARB;
    cand_sel = 4'h0;
    cand_vec = VEC_RESET;
    if (rst_pend_ff) begin
      cand_kind = K_RESET; // (R6)
    end else if (|hwtrap_pend_ff) begin
      cand_kind = K_HWTRAP; // (R7)
      for (int t = NUM_HWTRAP - 1; t >= 0; t--) begin
        if (hwtrap_pend_ff[t]) begin
          cand_sel = 4'(t);
        end
      end
      cand_vec = VEC_HWTRAP_BASE + {10'h000, cand_sel, 2'b00}; // (R7)
    end else if (|swtrap_pend_ff) begin
      cand_kind = K_SWTRAP;
      for (int t = NUM_SWTRAP - 1; t >= 0; t--) begin
        if (swtrap_pend_ff[t]) begin
          cand_sel = 4'(t);
        end
      end
      cand_vec = VEC_SWTRAP_BASE + {10'h000, cand_sel, 2'b00}; // (R8)
    end else begin
      cand_valid = arb_found && (arb_best > core_pri); // (R16)
      cand_sel = arb_idx;
      if (arb_idx < 4'(NUM_EVT)) begin
        cand_vec = vic_evt_vec(int'(arb_idx)); // (R9)
      end else begin
        cand_vec = VEC_SWI_BASE + {10'h000, 4'(arb_idx - 4'(NUM_EVT)), 2'b00};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector hand-off to the core
  assign taken = (state_ff == ST_PRESENT) && vec_ack;
  assign taken_rst = taken && kind_ff == K_RESET;
  assign taken_hw = taken && kind_ff == K_HWTRAP;
  assign taken_sw = taken && kind_ff == K_SWTRAP;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      vec_valid_ff <= 1'b0;
      vec_addr_ff <= VEC_RESET;
      kind_ff <= K_RESET;
      sel_ff <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (cand_valid) begin
            state_ff <= ST_PRESENT;
            vec_valid_ff <= 1'b1;
            vec_addr_ff <= cand_vec; // (R13)
            kind_ff <= cand_kind;
            sel_ff <= cand_sel;
          end
        end
        ST_PRESENT: begin
          // Choice is frozen while presented; a newer request waits for the ack
          if (vec_ack) begin
            state_ff <= ST_IDLE;
            vec_valid_ff <= 1'b0;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          vec_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending exceptions and traps; a new request beats a same-cycle clear
  always_comb begin
    hw_clr = '0;
    sw_clr = '0;
    // Compare per bit, so a stray select never indexes past the vector
    for (int t = 0; t < NUM_HWTRAP; t++) begin
      hw_clr[t] = taken_hw && sel_ff == 4'(t);
    end
    for (int t = 0; t < NUM_SWTRAP; t++) begin
      sw_clr[t] = taken_sw && sel_ff == 4'(t);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_pend_ff <= 1'b1; // (R13)
      hwtrap_pend_ff <= '0;
      swtrap_pend_ff <= '0;
    end else begin
      rst_pend_ff <= (rst_pend_ff && !taken_rst)
          || wdt_reset || sw_reset; // (R6)
      hwtrap_pend_ff <= (hwtrap_pend_ff & ~hw_clr) | hw_trap; // (R7) (R12)
      swtrap_pend_ff <= (swtrap_pend_ff & ~sw_clr)
          | (swtrap_req ? (16'h0001 << swtrap_num) : 16'h0000); // (R8) (R12)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up: pins are asynchronous, so they are synchronised before use
  // Stages reset high, the idle level of the pins, so no false wake follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_ff <= 2'b11;
      pin_s2_ff <= 2'b11;
    end else begin
      pin_s1_ff <= ext_irq_n_pin;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Edge mode cannot wake power-down since the clock is stopped there
  assign nxt_wake = (idle_mode && cand_valid) // (R14)
      || (pd_mode && en_lo_ff[EN_GLOBAL_BIT]
          && ((en_lo_ff[0] && extlvl_ff[0] && !pin_s2_ff[0])
              || (en_lo_ff[1] && extlvl_ff[1] && !pin_s2_ff[1]))); // (R15)

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt output
  assign st_set = {taken_rst, nxt_wake && !wake_ff, taken};
  assign st_clr = (acc_wr && paddr == ADDR_STATUS) ? pwdata[2:0] : 3'h0;

  // A set in the same cycle as its write-one-to-clear survives
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ff <= 1'b0;
      status_ff <= STAT_RST;
    end else begin
      wake_ff <= nxt_wake;
      status_ff <= (status_ff & ~st_clr) | st_set;
    end
  end

  // Level output, one cycle behind the status it reflects
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & mask_ff);
    end
  end
endmodule
`default_nettype wire

// file: bench/vic_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module vic_top_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic wdt_reset,
  input wire logic sw_reset,
  input wire logic vec_ack,
  input wire logic vec_valid_ff,
  input wire logic [15:0] vec_addr_ff,
  input wire logic idle_mode,
  input wire logic pd_mode,
  input wire logic wake_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  apb_ready_a: assert property (psel && !penable |=> pready_ff ##1 !pready_ff)
    else $error("ready is not one cycle after setup");
  unmapped_err_a: assert property (psel && !penable && paddr == 8'h14 |=> pslverr_ff)
    else $error("hole in the priority map not refused");
  reset_vec_a: assert property ($fell(rst) |=> vec_valid_ff && vec_addr_ff == 16'h0000)
    else $error("no reset vector after release");
  reset_req_a: assert property ((wdt_reset || sw_reset) |->
      ##[2:12] vec_valid_ff && vec_addr_ff == 16'h0000)
    else $error("watchdog or software reset not vectored");
  vec_hold_a: assert property (vec_valid_ff && !vec_ack |=> vec_valid_ff && $stable(vec_addr_ff))
    else $error("vector changed before acknowledge");
  vec_drop_a: assert property (vec_valid_ff && vec_ack |=> !vec_valid_ff)
    else $error("vector kept after acknowledge");
  wake_cause_a: assert property ($rose(wake_ff) |->
      $past(idle_mode) || $past(pd_mode))
    else $error("wake outside a power state");
  vec_page_a: assert property ($rose(vec_valid_ff) |->
      vec_addr_ff[1:0] == 2'b00 && vec_addr_ff <= 16'h011B)
    else $error("vector not an aligned table entry");
  cover property ($fell(rst) ##1 vec_valid_ff);
  cover property (vec_valid_ff && vec_ack && vec_addr_ff == 16'h0080);
  cover property ($rose(wake_ff) && pd_mode);
endmodule
`default_nettype wire

// file: bench/vic_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic vec_valid_ff,
  input wire logic [15:0] vec_addr_ff,
  output logic vec_ack,
  output logic [15:0] taken_ff,
  output logic took_ff
);
  logic [1:0] wait_ff;
  // Vector is taken at the acknowledge edge; slow mode gives software time to act
  always_ff @(posedge clk) begin
    took_ff <= 1'b0;
    if (rst) begin
      vec_ack <= 1'b0;
      wait_ff <= 2'h0;
      taken_ff <= 16'h0000;
    end else if (vec_ack) begin
      vec_ack <= 1'b0;
      took_ff <= 1'b1;
      taken_ff <= vec_addr_ff;
    end else if (vec_valid_ff) begin
      if (slow && wait_ff != 2'h3) begin
        wait_ff <= wait_ff + 2'h1;
      end else begin
        vec_ack <= 1'b1;
        wait_ff <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/vic_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vic_top_tb;
  import vic_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, swtrap_req = 0, slow = 0;
  logic wdt_reset = 0, sw_reset = 0, idle_mode = 0, pd_mode = 0, vec_ack, took_ff, er;
  logic pready_ff, pslverr_ff, vec_valid_ff, wake_ff, irq_ff;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata_ff, rd;
  logic [3:0] core_pri = 4'h0, swtrap_num = 4'h0;
  logic [4:0] hw_trap = 5'h00;
  logic [1:0] ext_irq_n_pin = 2'h3;
  logic [9:0] flg = 10'h000;
  logic [15:0] vec_addr_ff, taken_ff;
  logic [15:0] q[$];
  logic [2:0] p [9];
  logic [7:0] gen [3] = '{8'h1F, 8'h9E, 8'h9F};
  logic [15:0] vtab [9] = '{16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090, 16'h00A0,
    16'h00A4, 16'h00A8, 16'h00AC};
  int errors = 0, n_compared = 0, cyc = 0, t, i, k, la, lb;
  wire logic ext_irq0_flag, timer0_overflow_flag, ext_irq1_flag, timer1_overflow_flag;
  wire logic timer2_overflow_flag, uart0_rx_flag, uart0_tx_flag, uart1_rx_flag;
  wire logic uart1_tx_flag, timer2_external_flag;
  assign {timer2_external_flag, uart1_tx_flag, uart1_rx_flag, uart0_tx_flag, uart0_rx_flag,
    timer2_overflow_flag, timer1_overflow_flag, ext_irq1_flag, timer0_overflow_flag,
    ext_irq0_flag} = flg;
  vic_top uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff, .pready_ff,
    .pslverr_ff, .ext_irq0_flag, .ext_irq1_flag, .timer0_overflow_flag, .timer1_overflow_flag,
    .timer2_overflow_flag, .timer2_external_flag, .uart0_rx_flag, .uart0_tx_flag,
    .uart1_rx_flag, .uart1_tx_flag, .core_pri, .hw_trap, .swtrap_req, .swtrap_num, .wdt_reset,
    .sw_reset, .vec_ack, .vec_valid_ff, .vec_addr_ff, .idle_mode, .pd_mode, .ext_irq_n_pin,
    .wake_ff, .irq_ff);
  vic_core_model core (.clk, .rst, .slow, .vec_valid_ff, .vec_addr_ff, .vec_ack, .taken_ff,
    .took_ff);
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (took_ff === 1'b1) q.push_back(taken_ff);
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One idle cycle before each setup keeps every signal to one change per edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No fixed latency is assumed; only the cycle ceiling ends a lost answer
    do begin
      @(posedge clk);
    end while (pready_ff !== 1'b1);
    rd = prdata_ff;
    er = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flags drop once presented, since an acknowledge leaves the peripheral flag set
  task automatic ev(input logic [15:0] e);
    for (t = 0; t < 60 && q.size() == 0; t++) begin
      @(posedge clk);
      if (vec_valid_ff === 1'b1) flg <= 10'h000;
    end
    rd = (q.size() > 0) ? {16'h0000, q.pop_front()} : 32'hFFFF_FFFF;
    chk("vector", rd, {16'h0000, e});
  endtask
  task automatic none;
    repeat (6) @(posedge clk);
    chk("no vector", 32'(q.size()), 32'h0000_0000);
  endtask
  task automatic wake_wait;
    for (t = 0; t < 8 && wake_ff !== 1'b1; t++) @(posedge clk);
  endtask
  function automatic logic [3:0] eff(input logic [2:0] x);
    return (x == 3'h0) ? 4'h0 : {1'b1, x};
  endfunction
  function automatic int fi(input int l);
    return (l == 4 && k[0]) ? 9 : l;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ev(16'h0000);
    apb(1'b0, ADDR_EN_LO, 32'h0000_0000);
    chk("enable low", rd, 32'h0000_0000);
    apb(1'b0, ADDR_PRI_HOLE, 32'h0000_0000);
    chk("hole error", 32'(er), 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("reset status", rd & 32'h0000_0004, 32'h0000_0004);
    chk("irq masked", 32'(irq_ff), 32'h0000_0000);
    apb(1'b1, ADDR_MASK, 32'h0000_0004);
    repeat (3) @(posedge clk);
    chk("irq raised", 32'(irq_ff), 32'h0000_0001);
    apb(1'b1, ADDR_STATUS, 32'h0000_0007);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'(irq_ff), 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      if (i == 3) continue;
      apb(1'b1, ADDR_PRI_BASE + 8'(4 * i), 32'h0000_00FF);
      apb(1'b0, ADDR_PRI_BASE + 8'(4 * i), 32'h0000_0000);
      chk("priority field", rd, 32'h0000_0077);
    end
    apb(1'b1, ADDR_EN_HI, 32'h0000_000F);
    for (k = 0; k < 3; k++) begin
      apb(1'b1, ADDR_EN_LO, {24'h00_0000, gen[k]});
      core_pri <= (k == 2) ? 4'hF : 4'h0;
      flg <= 10'h001;
      none();
      flg <= 10'h000;
    end
    core_pri <= 4'h0;
    flg <= 10'h001;
    ev(16'h0080);
    for (i = 0; i < 5; i++) begin
      hw_trap <= 5'(1 << i);
      @(posedge clk);
      hw_trap <= 5'h00;
      ev(16'h0004 + 16'(4 * i));
    end
    for (k = 0; k < 8; k++) begin
      swtrap_num <= (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
      swtrap_req <= 1'b1;
      @(posedge clk);
      swtrap_req <= 1'b0;
      ev(16'h0040 + 16'(4 * swtrap_num));
    end
    for (k = 0; k < 2; k++) begin
      wdt_reset <= (k == 0);
      sw_reset <= (k == 1);
      hw_trap <= 5'h04;
      swtrap_req <= 1'b1;
      swtrap_num <= 4'h3;
      @(posedge clk);
      {wdt_reset, sw_reset, hw_trap, swtrap_req} <= 8'h00;
      ev(16'h0000);
      ev(16'h000C);
      ev(16'h004C);
    end
    slow <= 1'b1;
    apb(1'b1, ADDR_SWEN, 32'h0000_007F);
    for (k = 1; k < 8; k++) begin
      apb(1'b1, ADDR_SWREQ, 32'(1 << (k - 1)));
      for (t = 0; t < 20 && vec_valid_ff !== 1'b1; t++) @(posedge clk);
      apb(1'b1, ADDR_SWREQ, 32'h0000_0000);
      ev(16'h0100 + 16'(4 * (k - 1)));
    end
    slow <= 1'b0;
    for (k = 0; k < 30; k++) begin
      la = $urandom % 9;
      lb = (la + 1 + $urandom % 8) % 9;
      for (i = 0; i < 9; i++) p[i] = 3'($urandom);
      if (p[lb] == 3'h0) p[lb] = 3'h1;
      if (k % 3 == 0) p[la] = p[lb];
      apb(1'b1, 8'h08, {24'h00_0000, 1'b0, p[1], 1'b0, p[0]});
      apb(1'b1, 8'h0C, {24'h00_0000, 1'b0, p[3], 1'b0, p[2]});
      apb(1'b1, 8'h10, {28'h000_0000, 1'b0, p[4]});
      apb(1'b1, 8'h18, {24'h00_0000, 1'b0, p[6], 1'b0, p[5]});
      apb(1'b1, 8'h1C, {24'h00_0000, 1'b0, p[8], 1'b0, p[7]});
      flg <= (10'h001 << fi(la)) | (10'h001 << fi(lb));
      i = (eff(p[lb]) > eff(p[la]) || (eff(p[lb]) == eff(p[la]) && lb < la)) ? lb : la;
      ev(vtab[i]);
      repeat (10) @(posedge clk);
      q.delete();
    end
    idle_mode <= 1'b1;
    flg <= 10'h001 << fi(lb);
    wake_wait();
    chk("idle wake", 32'(wake_ff), 32'h0000_0001);
    flg <= 10'h000;
    idle_mode <= 1'b0;
    pd_mode <= 1'b1;
    ext_irq_n_pin <= 2'b10;
    repeat (6) @(posedge clk);
    chk("edge mode wake", 32'(wake_ff), 32'h0000_0000);
    apb(1'b1, ADDR_EXTLVL, 32'h0000_0001);
    wake_wait();
    chk("level wake", 32'(wake_ff), 32'h0000_0001);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk("wake status", rd & 32'h0000_0003, 32'h0000_0003);
    end_of_test();
  end
endmodule
bind vic_top vic_top_monitor mon (.clk, .rst, .psel, .penable, .paddr, .pready_ff,
  .pslverr_ff, .wdt_reset, .sw_reset, .vec_ack, .vec_valid_ff, .vec_addr_ff, .idle_mode,
  .pd_mode, .wake_ff);
`default_nettype wire
